// *** src/option_config_consts.vh ***
// constants for the option byte configuration decoder
// assumes a 32-bit AHB-Lite register window, one word per register
`ifndef OPTION_CONFIG_CONSTS_VH
`define OPTION_CONFIG_CONSTS_VH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define OFS_CLOCK_WATCHDOG   8'h00
`define OFS_WAKEUP_CLOCK     8'h04
`define OFS_CRYSTAL_SETTLE   8'h08
`define OFS_TEMP_UNPROTECT   8'h0c
`define OFS_FLASH_WAIT       8'h10
`define OFS_KEY0             8'h14
`define OFS_KEY1             8'h18
`define OFS_KEY2             8'h1c
`define OFS_KEY3             8'h20
`define OFS_RUNTIME_CTRL     8'h24
`define OFS_STATUS           8'h28

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define BIT_SLOW_RC_ALLOW    0
`define BIT_INDEP_HW         1
`define BIT_WINDOW_HW        2
`define BIT_WINDOW_HALT      3
`define BIT_DIRECT_CLOCK     4
`define BIT_WAKE_SRC         2
`define BIT_PRESCALE_HI      1
`define BIT_PRESCALE_LO      0
`define BIT_WAIT_STATE       0
`define BIT_REG_OFF          0
`define BIT_FLASH_PD         1

// ----------------------------------------------------------------------
// encodings and reset values
// ----------------------------------------------------------------------
`define SETTLE_CODE_HALF     8'he1
`define SETTLE_CODE_8        8'hd2
`define SETTLE_CODE_128      8'hb4
`define SETTLE_CODE_2048     8'h00
`define SETTLE_CYC_HALF      12'h000
`define SETTLE_CYC_8         12'h008
`define SETTLE_CYC_128       12'h080
`define SETTLE_CYC_2048      12'h800
`define UNPROTECT_OFF_CODE   4'h5
`define KEY_BAD_LOW          8'h00
`define KEY_BAD_HIGH         8'hff
`define PRESCALE_DIV_24      8'hbb
`define PRESCALE_DIV_16      8'h7d
`define PRESCALE_DIV_8       8'h3e
`define PRESCALE_DIV_4       8'h1f
`define RUNTIME_RESET        2'h0

`endif

// *** src/settle_decode.v ***
// crystal settle code and wakeup prescale decode
// assumes codes come from the option byte latch; pure combinational
`timescale 1ns/1ps
`default_nettype none
`include "option_config_consts.vh"

module settle_decode (
  input  wire [7:0]  settle_code,
  input  wire [1:0]  prescale_code,
  output reg  [11:0] settle_cycles,
  output reg         settle_half,
  output reg         settle_valid,
  output reg  [7:0]  prescale_div
);

  always @* begin
    settle_half   = 1'b0;
    settle_valid  = 1'b1;
    // unknown codes fall back to the longest wait, the safe choice
    if (settle_code == `SETTLE_CODE_HALF) begin
      settle_cycles = `SETTLE_CYC_HALF;
      settle_half   = 1'b1;
    end else if (settle_code == `SETTLE_CODE_8) begin
      settle_cycles = `SETTLE_CYC_8;
    end else if (settle_code == `SETTLE_CODE_128) begin
      settle_cycles = `SETTLE_CYC_128;
    end else if (settle_code == `SETTLE_CODE_2048) begin
      settle_cycles = `SETTLE_CYC_2048;
    end else begin
      settle_cycles = `SETTLE_CYC_2048;
      settle_valid  = 1'b0;
    end
    // divider ratio (minus one) bringing the oscillator to 128 kHz
    case (prescale_code)
      2'b00:   prescale_div = `PRESCALE_DIV_24;
      2'b01:   prescale_div = `PRESCALE_DIV_16;
      2'b10:   prescale_div = `PRESCALE_DIV_8;
      default: prescale_div = `PRESCALE_DIV_4;
    endcase
  end

endmodule // settle_decode
`default_nettype wire

// *** src/option_byte_config_decoder.v ***
// option byte decoder: latches option bytes at reset release and drives
// static configuration to clock, watchdog, wakeup and flash units
// assumes a single AHB-Lite master; option values arrive as input buses
//
// The implementer's own choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "option_config_consts.vh"

module option_byte_config_decoder (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire [7:0]  opt_clock_watchdog,
  input  wire [7:0]  opt_wakeup_clock,
  input  wire [7:0]  opt_crystal_settle,
  input  wire [7:0]  opt_temp_unprotect,
  input  wire [7:0]  opt_flash_wait,
  input  wire [7:0]  opt_key0,
  input  wire [7:0]  opt_key1,
  input  wire [7:0]  opt_key2,
  input  wire [7:0]  opt_key3,
  input  wire        window_dog_active,
  input  wire        halt_entry,
  output reg         slow_rc_cpu_clock_allow,
  output reg         indep_dog_hw_start,
  output reg         window_dog_hw_start,
  output reg         halt_reset_request,
  output reg         direct_clock_input_select,
  output reg         wakeup_clock_source_select,
  output reg  [7:0]  wakeup_prescale_div,
  output reg  [11:0] crystal_settle_cycles,
  output reg         crystal_settle_half,
  output reg         temporary_unprotect,
  output reg         flash_wait_state,
  output reg         regulator_off_in_deep_idle,
  output reg         flash_powerdown_in_deep_idle
);

  // --------------------------------------------------------------------
  // option byte latch
  // --------------------------------------------------------------------
  // captured on the first edge after reset release; the async reset only
  // loads constants, so the capture is a clocked step
  reg        loaded_reg;
  reg [7:0]  opt_reg [0:8];
  wire [7:0] opt_in [0:8];
  assign opt_in[0] = opt_clock_watchdog;
  assign opt_in[1] = opt_wakeup_clock;
  assign opt_in[2] = opt_crystal_settle;
  assign opt_in[3] = opt_temp_unprotect;
  assign opt_in[4] = opt_flash_wait;
  assign opt_in[5] = opt_key0;
  assign opt_in[6] = opt_key1;
  assign opt_in[7] = opt_key2;
  assign opt_in[8] = opt_key3;

  genvar gi;
  generate
    for (gi = 0; gi < 9; gi = gi + 1) begin : g_opt
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          opt_reg[gi] <= 8'h00;
        end else if (!loaded_reg) begin
          opt_reg[gi] <= opt_in[gi];
        end
      end
    end
  endgenerate

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      loaded_reg <= 1'b0;
    end else begin
      // one capture edge, then the image is frozen until the next reset
      loaded_reg <= 1'b1;
    end
  end

  // --------------------------------------------------------------------
  // latched option images
  // --------------------------------------------------------------------
  wire [7:0] cw  = opt_reg[0];
  wire [7:0] wk  = opt_reg[1];

  // --------------------------------------------------------------------
  // decode
  // --------------------------------------------------------------------
  // pure logic; every decoded result but settle_valid (left open) is registered at the outputs
  wire [11:0] settle_cycles_w;
  wire        settle_half_w;
  wire [7:0]  prescale_div_w;

  settle_decode u_settle_decode (
    .settle_code   (opt_reg[2]),
    .prescale_code ({wk[`BIT_PRESCALE_HI], wk[`BIT_PRESCALE_LO]}),
    .settle_cycles (settle_cycles_w),
    .settle_half   (settle_half_w),
    .settle_valid  (),
    .prescale_div  (prescale_div_w)
  );

  // --------------------------------------------------------------------
  // unprotect key check
  // --------------------------------------------------------------------
  // keys are only reported in status, never enforced: choosing legal
  // keys is the job of whoever programs the option bytes
  wire [3:0] key_ok;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_key
      assign key_ok[gi] = (opt_reg[5 + gi] != `KEY_BAD_LOW) &&
                          (opt_reg[5 + gi] != `KEY_BAD_HIGH);
    end
  endgenerate
  wire keys_ok = &key_ok;

  // --------------------------------------------------------------------
  // runtime deep idle control and bus slave
  // --------------------------------------------------------------------
  reg [1:0]  runtime_reg;
  reg        wr_pend_reg;
  reg [7:0]  wr_addr_reg;
  reg [31:0] rdata_next;

  wire access = hsel && hready && htrans[1];
  // only the low byte is decoded; anything above it must not alias
  wire low_page = (haddr[31:8] == 24'h000000);

  // --------------------------------------------------------------------
  // status word
  // --------------------------------------------------------------------
  // bit 0 latch done, bit 1 unprotect active, bit 2 all keys usable
  wire [31:0] status_word = {29'h00000000, keys_ok, temporary_unprotect,
                             loaded_reg};

  always @* begin
    rdata_next = 32'h0000_0000;
    if (haddr[7:0] == `OFS_CLOCK_WATCHDOG) begin
      rdata_next = {24'h000000, cw};
    end else if (haddr[7:0] == `OFS_WAKEUP_CLOCK) begin
      rdata_next = {24'h000000, wk};
    end else if (haddr[7:0] == `OFS_CRYSTAL_SETTLE) begin
      rdata_next = {24'h000000, opt_reg[2]};
    end else if (haddr[7:0] == `OFS_TEMP_UNPROTECT) begin
      rdata_next = {24'h000000, opt_reg[3]};
    end else if (haddr[7:0] == `OFS_FLASH_WAIT) begin
      rdata_next = {24'h000000, opt_reg[4]};
    end else if (haddr[7:0] == `OFS_KEY0) begin
      rdata_next = {24'h000000, opt_reg[5]};
    end else if (haddr[7:0] == `OFS_KEY1) begin
      rdata_next = {24'h000000, opt_reg[6]};
    end else if (haddr[7:0] == `OFS_KEY2) begin
      rdata_next = {24'h000000, opt_reg[7]};
    end else if (haddr[7:0] == `OFS_KEY3) begin
      rdata_next = {24'h000000, opt_reg[8]};
    end else if (haddr[7:0] == `OFS_RUNTIME_CTRL) begin
      rdata_next = {30'h00000000, runtime_reg};
    end else if (haddr[7:0] == `OFS_STATUS) begin
      rdata_next = status_word;
    end
    // unmapped offsets and anything above the low page read as zero
    if (!low_page) begin
      rdata_next = 32'h0000_0000;
    end
  end

  // --------------------------------------------------------------------
  // bus handshake: zero wait states, always an okay response
  // --------------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // address phase capture and read data
  // --------------------------------------------------------------------
  // the write target is kept for the data phase, where hwdata stands
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= access && hwrite && low_page;
      if (access) begin
        wr_addr_reg <= haddr[7:0];
      end
    end
  end

  // hrdata holds between reads, so a late sample still sees the word
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (access && !hwrite) begin
      hrdata <= rdata_next;
    end
  end

  // --------------------------------------------------------------------
  // runtime control register
  // --------------------------------------------------------------------
  // option bytes are read only here: their image is fixed until reset
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      runtime_reg <= `RUNTIME_RESET;
    end else if (wr_pend_reg && wr_addr_reg == `OFS_RUNTIME_CTRL) begin
      runtime_reg <= hwdata[1:0];
    end
  end

  // --------------------------------------------------------------------
  // clock and watchdog configuration
  // --------------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slow_rc_cpu_clock_allow   <= 1'b0;
      indep_dog_hw_start        <= 1'b0;
      window_dog_hw_start       <= 1'b0;
      halt_reset_request        <= 1'b0;
      direct_clock_input_select <= 1'b0;
    end else begin
      slow_rc_cpu_clock_allow   <= cw[`BIT_SLOW_RC_ALLOW];
      indep_dog_hw_start        <= cw[`BIT_INDEP_HW];
      window_dog_hw_start       <= cw[`BIT_WINDOW_HW];
      // a level, not a pulse: it stands while both inputs stand
      halt_reset_request        <= loaded_reg &&
                                   cw[`BIT_WINDOW_HALT] &&
                                   window_dog_active &&
                                   halt_entry;
      direct_clock_input_select <= cw[`BIT_DIRECT_CLOCK];
    end
  end

  // --------------------------------------------------------------------
  // wakeup clock and crystal settle configuration
  // --------------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wakeup_clock_source_select <= 1'b0;
      wakeup_prescale_div        <= `PRESCALE_DIV_24;
      crystal_settle_cycles      <= `SETTLE_CYC_2048;
      crystal_settle_half        <= 1'b0;
    end else begin
      wakeup_clock_source_select <= wk[`BIT_WAKE_SRC];
      wakeup_prescale_div        <= prescale_div_w;
      crystal_settle_cycles      <= settle_cycles_w;
      crystal_settle_half        <= settle_half_w;
    end
  end

  // --------------------------------------------------------------------
  // protection, flash and deep idle configuration
  // --------------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      temporary_unprotect          <= 1'b0;
      flash_wait_state             <= 1'b0;
      regulator_off_in_deep_idle   <= 1'b0;
      flash_powerdown_in_deep_idle <= 1'b0;
    end else begin
      // until the latch is done the part stays protected
      temporary_unprotect        <= loaded_reg &&
                                    (opt_reg[3][3:0] !=
                                     `UNPROTECT_OFF_CODE);
      flash_wait_state           <= opt_reg[4][`BIT_WAIT_STATE];
      regulator_off_in_deep_idle   <= runtime_reg[`BIT_REG_OFF];
      flash_powerdown_in_deep_idle <= runtime_reg[`BIT_FLASH_PD];
    end
  end

endmodule // option_byte_config_decoder
`default_nettype wire

// *** testbench/option_decoder_chk.sv ***
// checker: decoded outputs against the option bytes seen at the
// first edge after reset release; watches only the top module's ports
`timescale 1ns/1ps
`default_nettype none
module option_decoder_chk (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic [7:0]  opt_clock_watchdog,
  input wire logic [7:0]  opt_wakeup_clock,
  input wire logic [7:0]  opt_crystal_settle,
  input wire logic [7:0]  opt_temp_unprotect,
  input wire logic [7:0]  opt_flash_wait,
  input wire logic        window_dog_active,
  input wire logic        halt_entry,
  input wire logic        slow_rc_cpu_clock_allow,
  input wire logic        indep_dog_hw_start,
  input wire logic        window_dog_hw_start,
  input wire logic        halt_reset_request,
  input wire logic        direct_clock_input_select,
  input wire logic        wakeup_clock_source_select,
  input wire logic [7:0]  wakeup_prescale_div,
  input wire logic [11:0] crystal_settle_cycles,
  input wire logic        crystal_settle_half,
  input wire logic        temporary_unprotect,
  input wire logic        flash_wait_state
);
  localparam logic [7:0] PD [4] = '{8'hbb, 8'h7d, 8'h3e, 8'h1f};
  logic [1:0] up;
  logic [7:0] cw, wk, st, tu, fw;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ------------------------------------------------------------------
  // capture: copies follow the inputs until the first edge after reset
  // ------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) up <= 2'h0;
    else if (up != 2'h3) up <= up + 2'h1;
  always_ff @(posedge hclk)
    if (up == 2'h0) begin
      cw <= opt_clock_watchdog;
      wk <= opt_wakeup_clock;
      st <= opt_crystal_settle;
      tu <= opt_temp_unprotect;
      fw <= opt_flash_wait;
    end
  // ------------------------------------------------------------------
  // properties
  // ------------------------------------------------------------------
  chk_slow_rc_copy: assert property (
    up == 2'h3 |-> slow_rc_cpu_clock_allow == cw[0])
    else $error("slow rc allow differs from captured option");
  chk_indep_dog_copy: assert property (
    up == 2'h3 |-> indep_dog_hw_start == cw[1])
    else $error("independent watchdog start differs");
  chk_window_dog_copy: assert property (
    up == 2'h3 |-> window_dog_hw_start == cw[2])
    else $error("window watchdog start differs");
  chk_halt_reset_gate: assert property (
    up == 2'h3 |-> halt_reset_request ==
    $past(cw[3] & window_dog_active & halt_entry))
    else $error("halt reset request wrong");
  chk_direct_clock_copy: assert property (
    up == 2'h3 |-> direct_clock_input_select == cw[4])
    else $error("direct clock select differs");
  chk_wakeup_source_copy: assert property (
    up == 2'h3 |-> wakeup_clock_source_select == wk[2])
    else $error("wakeup source differs");
  chk_prescale_decode: assert property (
    up == 2'h3 |-> wakeup_prescale_div == PD[wk[1:0]])
    else $error("prescale divide wrong");
  chk_settle_decode: assert property (
    up == 2'h3 |-> {crystal_settle_half, crystal_settle_cycles} ==
    (st == 8'he1 ? 13'h1000 : st == 8'hd2 ? 13'h0008 :
     st == 8'hb4 ? 13'h0080 : 13'h0800))
    else $error("settle count wrong");
  chk_unprotect_decode: assert property (
    up == 2'h3 |-> temporary_unprotect == (tu[3:0] != 4'h5))
    else $error("temporary unprotect wrong");
  chk_wait_state_copy: assert property (
    up == 2'h3 |-> flash_wait_state == fw[0])
    else $error("wait state differs");
  cover property ($rose(halt_reset_request));
  cover property (up == 2'h3 && crystal_settle_half);
  cover property (up == 2'h3 && !temporary_unprotect);
endmodule // option_decoder_chk

bind option_byte_config_decoder option_decoder_chk chk_i (
  .hclk, .hresetn, .opt_clock_watchdog, .opt_wakeup_clock,
  .opt_crystal_settle, .opt_temp_unprotect, .opt_flash_wait,
  .window_dog_active, .halt_entry, .slow_rc_cpu_clock_allow,
  .indep_dog_hw_start, .window_dog_hw_start, .halt_reset_request,
  .direct_clock_input_select, .wakeup_clock_source_select,
  .wakeup_prescale_div, .crystal_settle_cycles, .crystal_settle_half,
  .temporary_unprotect, .flash_wait_state);
`default_nettype wire

// *** testbench/tb_top.sv ***
// bench: each option set is loaded through a reset, then the outputs
// and registers are compared; the one slave's hreadyout is hready
`timescale 1ns/1ps
`default_nettype none
`include "option_config_consts.vh"
module tb_top;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic        window_dog_active, halt_entry, crystal_settle_half;
  logic [7:0]  opt_clock_watchdog, opt_wakeup_clock, opt_crystal_settle;
  logic [7:0]  opt_temp_unprotect, opt_flash_wait, opt_key0, opt_key1;
  logic [7:0]  opt_key2, opt_key3, wakeup_prescale_div;
  logic [11:0] crystal_settle_cycles;
  logic        slow_rc_cpu_clock_allow, indep_dog_hw_start;
  logic        window_dog_hw_start, halt_reset_request;
  logic        direct_clock_input_select, wakeup_clock_source_select;
  logic        temporary_unprotect, flash_wait_state;
  logic        regulator_off_in_deep_idle, flash_powerdown_in_deep_idle;
  int          err_count, comparisons;
  logic [7:0]  cw_t [4] = '{8'h1f, 8'h00, 8'h15, 8'h0a};
  logic [7:0]  wk_t [4] = '{8'h00, 8'h05, 8'h02, 8'h07};
  logic [7:0]  st_t [4] = '{8'he1, 8'hd2, 8'hb4, 8'h00};
  logic [7:0]  tu_t [4] = '{8'h05, 8'h0a, 8'h00, 8'hf5};
  logic [7:0]  pd_t [4] = '{8'hbb, 8'h7d, 8'h3e, 8'h1f};
  logic [12:0] sc_t [4] = '{13'h1000, 13'h0008, 13'h0080, 13'h0800};
  logic [7:0]  key_t [4] = '{8'h5a, 8'ha5, 8'h3c, 8'h01};
  assign hready = hreadyout;
  option_byte_config_decoder uut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hrdata, .hreadyout, .hresp, .opt_clock_watchdog,
    .opt_wakeup_clock, .opt_crystal_settle, .opt_temp_unprotect,
    .opt_flash_wait, .opt_key0, .opt_key1, .opt_key2, .opt_key3,
    .window_dog_active, .halt_entry, .slow_rc_cpu_clock_allow,
    .indep_dog_hw_start, .window_dog_hw_start, .halt_reset_request,
    .direct_clock_input_select, .wakeup_clock_source_select,
    .wakeup_prescale_div, .crystal_settle_cycles, .crystal_settle_half,
    .temporary_unprotect, .flash_wait_state, .regulator_off_in_deep_idle,
    .flash_powerdown_in_deep_idle);
  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  task automatic end_of_test();
    if (err_count == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge hclk);
    while (hready !== 1'b1) begin
      n++;
      if (n > 50) begin
        err_count++;
        end_of_test();
      end
      @(posedge hclk);
    end
  endtask
  // one single transfer; the data phase is idle so hrdata stands
  task automatic bus(input logic w, input logic [31:0] a, d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
    check(hresp, 1'b0);
  endtask
  task automatic rd(input logic [31:0] a, exp);
    bus(1'b0, a, 32'h0);
    check(q, exp);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
    #2;
  endtask
  task automatic outs(input int i);
    check(slow_rc_cpu_clock_allow, cw_t[i][0]);
    check(indep_dog_hw_start, cw_t[i][1]);
    check(window_dog_hw_start, cw_t[i][2]);
    check(direct_clock_input_select, cw_t[i][4]);
    check(wakeup_clock_source_select, wk_t[i][2]);
    check(wakeup_prescale_div, pd_t[i]);
    check({crystal_settle_half, crystal_settle_cycles}, sc_t[i]);
    check(temporary_unprotect, tu_t[i][3:0] != 4'h5);
    check(flash_wait_state, i % 2);
  endtask
  // ------------------------------------------------------------------
  // clock and sequence
  // ------------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    {window_dog_active, halt_entry} = 2'h0;
    err_count = 0;
    comparisons = 0;
    for (int i = 0; i < 4; i++) begin
      hresetn <= 1'b0;
      opt_clock_watchdog <= cw_t[i];
      opt_wakeup_clock <= wk_t[i];
      opt_crystal_settle <= st_t[i];
      opt_temp_unprotect <= tu_t[i];
      opt_flash_wait <= 8'(i % 2);
      {opt_key0, opt_key1, opt_key2, opt_key3} <= {key_t[0], key_t[1],
        key_t[2], key_t[3]};
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      tick(3);
      outs(i);
      @(posedge hclk);
      opt_clock_watchdog <= ~cw_t[i];
      opt_wakeup_clock <= ~wk_t[i];
      opt_crystal_settle <= ~st_t[i];
      opt_temp_unprotect <= ~tu_t[i];
      opt_flash_wait <= ~opt_flash_wait;
      tick(3);
      outs(i);
      @(posedge hclk);
      window_dog_active <= 1'b1;
      halt_entry <= 1'b1;
      tick(3);
      check(halt_reset_request, cw_t[i][3]);
      @(posedge hclk);
      window_dog_active <= 1'b0;
      tick(3);
      check(halt_reset_request, 1'b0);
      @(posedge hclk);
      halt_entry <= 1'b0;
      rd(`OFS_RUNTIME_CTRL, 32'h0);
      bus(1'b1, `OFS_RUNTIME_CTRL, i);
      tick(2);
      check({flash_powerdown_in_deep_idle, regulator_off_in_deep_idle},
        i % 4);
      rd(`OFS_RUNTIME_CTRL, i);
      bus(1'b1, `OFS_KEY0, 32'hff);
      for (int k = 0; k < 4; k++)
        rd(`OFS_KEY0 + 4 * k, key_t[k]);
      rd(`OFS_STATUS, {29'h0, 1'b1, tu_t[i][3:0] != 4'h5, 1'b1});
      rd(32'h40, 32'h0);
    end
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
